// [logic/usb_endpoint_register_set.sv]
// Endpoint register set of a full-speed USB device controller, on AXI4-Lite.
// Assumes a packet decoder that strobes SOF, address, token and SETUP events.
//
// Decided for this implementation: the AXI4-Lite slave port.
module usb_endpoint_register_set (
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                nrst,
  // AXI4-Lite write address
  input  wire logic [usb_regs_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  // AXI4-Lite write data
  input  wire logic [usb_regs_pkg::AXI_DATA_W-1:0] wdata,
  input  wire logic [usb_regs_pkg::AXI_STRB_W-1:0] wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  // AXI4-Lite write response
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  // AXI4-Lite read address
  input  wire logic [usb_regs_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  // AXI4-Lite read data
  output logic [usb_regs_pkg::AXI_DATA_W-1:0]      rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  // Frame and address events from the packet decoder
  input  wire logic                                sof_valid,
  input  wire logic [usb_regs_pkg::FRAME_W-1:0]    sof_frame,
  input  wire logic                                addr_set_valid,
  input  wire logic [usb_regs_pkg::DEV_ADDR_W-1:0] addr_set_value,
  // Token events from the packet decoder
  input  wire logic                                token_valid,
  input  wire logic [usb_regs_pkg::DEV_ADDR_W-1:0] token_addr,
  input  wire logic [usb_regs_pkg::EP_W-1:0]       token_ep,
  input  wire logic                                token_is_in,
  input  wire logic                                iso_in_empty,
  // SETUP data bytes from the packet decoder
  input  wire logic                                setup_start,
  input  wire logic                                setup_byte_valid,
  input  wire logic [usb_regs_pkg::REG_W-1:0]      setup_byte,
  // Token decision, one-cycle pulses
  output logic                                     token_respond,
  output logic                                     token_ignore,
  output logic                                     zero_length_reply,
  // Endpoint pairing levels
  output logic                                     pair_out_four_five,
  output logic                                     pair_out_two_three,
  output logic                                     pair_in_six_seven,
  output logic                                     pair_in_four_five,
  output logic                                     pair_in_two_three,
  // Isochronous buffer start addresses
  output logic [usb_regs_pkg::BUF_ADDR_W-1:0]      iso_out_buffer_start,
  output logic [usb_regs_pkg::BUF_ADDR_W-1:0]      iso_in_buffer_start
);

  typedef enum logic [1:0] {
    wr_idle = 2'b01,
    wr_resp = 2'b10
  } wr_state_type;

  typedef enum logic [1:0] {
    rd_idle = 2'b01,
    rd_resp = 2'b10
  } rd_state_type;

  // Bus channel state
  wr_state_type                         wr_state_q;
  rd_state_type                         rd_state_q;
  logic                                 aw_got_q;
  logic                                 w_got_q;
  logic [usb_regs_pkg::IDX_W-1:0]       wr_idx_q;
  logic [usb_regs_pkg::REG_W-1:0]       wr_byte_q;
  logic                                 wr_lane_q;
  logic [1:0]                           bresp_q;
  logic [usb_regs_pkg::AXI_DATA_W-1:0]  rdata_q;
  logic [1:0]                           rresp_q;

  // Register file
  logic [usb_regs_pkg::FRAME_W-1:0]     frame_q;
  logic [usb_regs_pkg::DEV_ADDR_W-1:0]  dev_addr_q;
  logic [usb_regs_pkg::REG_W-1:0]       pairing_q;
  logic [usb_regs_pkg::EP_MASK_W-1:0]   in_mask_q;
  logic [usb_regs_pkg::EP_MASK_W-1:0]   out_mask_q;
  logic                                 iso_in_en_q;
  logic                                 iso_out_en_q;
  logic [usb_regs_pkg::BUF_FIELD_W-1:0] iso_out_buf_q;
  logic [usb_regs_pkg::BUF_FIELD_W-1:0] iso_in_buf_q;
  logic [usb_regs_pkg::REG_W-1:0]       setup_mem_q [0:usb_regs_pkg::SETUP_BYTES-1];
  logic [usb_regs_pkg::SETUP_IDX_W-1:0] setup_ptr_q;

  // Decode helpers
  logic                                 do_write;
  logic                                 wr_en;
  logic                                 wr_mapped;
  logic                                 rd_take;
  logic [usb_regs_pkg::IDX_W-1:0]       rd_idx;
  logic                                 rd_hit_setup;
  logic                                 rd_mapped;
  logic [usb_regs_pkg::REG_W-1:0]       rd_byte_d;

  // Handshakes decoded from state; data from flops
  assign awready  = (wr_state_q == wr_idle) && !aw_got_q;
  assign wready   = (wr_state_q == wr_idle) && !w_got_q;
  assign bvalid   = (wr_state_q == wr_resp);
  assign bresp    = bresp_q;
  assign arready  = (rd_state_q == rd_idle);
  assign rvalid   = (rd_state_q == rd_resp);
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;
  assign do_write = (wr_state_q == wr_idle) && aw_got_q && w_got_q;
  assign wr_en    = do_write && wr_lane_q; // Only byte lane 0 carries register data

  // Address and data latched separately, in either order
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_got_q  <= 1'b0;
      wr_idx_q  <= '0;
    end else if (awvalid && awready) begin
      aw_got_q  <= 1'b1;
      wr_idx_q  <= awaddr[usb_regs_pkg::AXI_ADDR_W-1:2];
    end else if (do_write) begin
      aw_got_q  <= 1'b0;
    end
  end

  // Write data; upper byte lanes have no storage
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      w_got_q   <= 1'b0;
      wr_byte_q <= usb_regs_pkg::RST_REG8;
      wr_lane_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_got_q   <= 1'b1;
      wr_byte_q <= wdata[usb_regs_pkg::REG_W-1:0];
      wr_lane_q <= wstrb[0];
    end else if (do_write) begin
      w_got_q   <= 1'b0;
    end
  end

  // Mapped indices; read-only ones answer OKAY unchanged
  always_comb begin
    case (wr_idx_q)
      usb_regs_pkg::IDX_FRAME_LOW,
      usb_regs_pkg::IDX_FRAME_HIGH,
      usb_regs_pkg::IDX_DEV_ADDR,
      usb_regs_pkg::IDX_PAIRING,
      usb_regs_pkg::IDX_IN_MASK,
      usb_regs_pkg::IDX_OUT_MASK,
      usb_regs_pkg::IDX_ISO_IN_EN,
      usb_regs_pkg::IDX_ISO_OUT_EN,
      usb_regs_pkg::IDX_ISO_OUT_BUF,
      usb_regs_pkg::IDX_ISO_IN_BUF: wr_mapped = 1'b1;
      default: wr_mapped = (wr_idx_q[usb_regs_pkg::IDX_W-1:usb_regs_pkg::SETUP_IDX_W] ==
                            usb_regs_pkg::IDX_SETUP_BASE[usb_regs_pkg::IDX_W-1:usb_regs_pkg::SETUP_IDX_W]);
    endcase
  end

  // Write channel state machine
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wr_state_q <= wr_idle;
      bresp_q    <= usb_regs_pkg::RESP_OKAY;
    end else begin
      case (wr_state_q)
        wr_idle: begin
          if (do_write) begin
            wr_state_q <= wr_resp;
            bresp_q    <= wr_mapped ? usb_regs_pkg::RESP_OKAY : usb_regs_pkg::RESP_SLVERR;
          end
        end
        wr_resp: begin
          if (bready) begin
            wr_state_q <= wr_idle;
          end
        end
        default: wr_state_q <= wr_idle;
      endcase
    end
  end

  // Pairing and zero-length reply control; bits 6:5 hold no storage
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pairing_q <= usb_regs_pkg::RST_REG8;
    end else if (wr_en && wr_idx_q == usb_regs_pkg::IDX_PAIRING) begin
      pairing_q <= wr_byte_q & usb_regs_pkg::PAIR_MASK;
    end
  end

  // Endpoint masks; bits 7:6 read as zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      in_mask_q  <= '0;
      out_mask_q <= '0;
    end else if (wr_en) begin
      if (wr_idx_q == usb_regs_pkg::IDX_IN_MASK) begin
        in_mask_q  <= wr_byte_q[usb_regs_pkg::EP_MASK_W-1:0];
      end
      if (wr_idx_q == usb_regs_pkg::IDX_OUT_MASK) begin
        out_mask_q <= wr_byte_q[usb_regs_pkg::EP_MASK_W-1:0];
      end
    end
  end

  // Isochronous endpoint enables
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      iso_in_en_q  <= 1'b0;
      iso_out_en_q <= 1'b0;
    end else if (wr_en) begin
      if (wr_idx_q == usb_regs_pkg::IDX_ISO_IN_EN) begin
        iso_in_en_q  <= wr_byte_q[usb_regs_pkg::ISO_EN_BIT];
      end
      if (wr_idx_q == usb_regs_pkg::IDX_ISO_OUT_EN) begin
        iso_out_en_q <= wr_byte_q[usb_regs_pkg::ISO_EN_BIT];
      end
    end
  end

  // Isochronous buffer starts keep only address bits 9:4
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      iso_out_buf_q <= '0;
      iso_in_buf_q  <= '0;
    end else if (wr_en) begin
      if (wr_idx_q == usb_regs_pkg::IDX_ISO_OUT_BUF) begin
        iso_out_buf_q <= wr_byte_q[usb_regs_pkg::REG_W-1:usb_regs_pkg::BUF_FIELD_LSB];
      end
      if (wr_idx_q == usb_regs_pkg::IDX_ISO_IN_BUF) begin
        iso_in_buf_q  <= wr_byte_q[usb_regs_pkg::REG_W-1:usb_regs_pkg::BUF_FIELD_LSB];
      end
    end
  end

  // Frame number loaded from each SOF; ten bits, taken as sent, not counted
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      frame_q <= usb_regs_pkg::RST_FRAME;
    end else if (sof_valid) begin
      frame_q <= sof_frame;
    end
  end

  // Function address from the host; software writes never reach it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dev_addr_q <= usb_regs_pkg::RST_DEV_ADDR;
    end else if (addr_set_valid) begin
      dev_addr_q <= addr_set_value;
    end
  end

  // SETUP capture; a new packet restarts at byte 0
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      setup_ptr_q <= '0;
    end else if (setup_start) begin
      setup_ptr_q <= '0;
    end else if (setup_byte_valid) begin
      setup_ptr_q <= setup_ptr_q + 1'b1;
    end
  end

  // SETUP storage; unreset so it maps onto RAM
  always_ff @(posedge mclk) begin
    if (setup_byte_valid && !setup_start) begin
      setup_mem_q[setup_ptr_q] <= setup_byte;
    end
  end

  // Read decode
  assign rd_take      = arvalid && arready;
  assign rd_idx       = araddr[usb_regs_pkg::AXI_ADDR_W-1:2];
  assign rd_hit_setup = (rd_idx[usb_regs_pkg::IDX_W-1:usb_regs_pkg::SETUP_IDX_W] ==
                         usb_regs_pkg::IDX_SETUP_BASE[usb_regs_pkg::IDX_W-1:usb_regs_pkg::SETUP_IDX_W]);

  // Read multiplexer; unused bits read as zero
  always_comb begin
    rd_byte_d = '0;
    rd_mapped = 1'b1;
    case (rd_idx)
      usb_regs_pkg::IDX_FRAME_LOW:   rd_byte_d = frame_q[usb_regs_pkg::FRAME_LOW_W-1:0];
      usb_regs_pkg::IDX_FRAME_HIGH:  rd_byte_d = 8'(frame_q[usb_regs_pkg::FRAME_W-1:usb_regs_pkg::FRAME_LOW_W]);
      usb_regs_pkg::IDX_DEV_ADDR:    rd_byte_d = 8'(dev_addr_q);
      usb_regs_pkg::IDX_PAIRING:     rd_byte_d = pairing_q;
      usb_regs_pkg::IDX_IN_MASK:     rd_byte_d = 8'(in_mask_q);
      usb_regs_pkg::IDX_OUT_MASK:    rd_byte_d = 8'(out_mask_q);
      usb_regs_pkg::IDX_ISO_IN_EN:   rd_byte_d = 8'(iso_in_en_q);
      usb_regs_pkg::IDX_ISO_OUT_EN:  rd_byte_d = 8'(iso_out_en_q);
      usb_regs_pkg::IDX_ISO_OUT_BUF: rd_byte_d = {iso_out_buf_q, 2'h0};
      usb_regs_pkg::IDX_ISO_IN_BUF:  rd_byte_d = {iso_in_buf_q, 2'h0};
      default: begin
        if (rd_hit_setup) begin
          rd_byte_d = setup_mem_q[rd_idx[usb_regs_pkg::SETUP_IDX_W-1:0]];
        end else begin
          rd_mapped = 1'b0;
        end
      end
    endcase
  end

  // Read channel; data sampled at the address handshake
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_state_q <= rd_idle;
      rdata_q    <= '0;
      rresp_q    <= usb_regs_pkg::RESP_OKAY;
    end else begin
      case (rd_state_q)
        rd_idle: begin
          if (rd_take) begin
            rd_state_q <= rd_resp;
            rdata_q    <= 32'(rd_byte_d);
            rresp_q    <= rd_mapped ? usb_regs_pkg::RESP_OKAY : usb_regs_pkg::RESP_SLVERR;
          end
        end
        rd_resp: begin
          if (rready) begin
            rd_state_q <= rd_idle;
          end
        end
        default: rd_state_q <= rd_idle;
      endcase
    end
  end

  // Pairing levels straight from the control flops
  assign pair_out_four_five = pairing_q[usb_regs_pkg::PAIR_OUT45_BIT];
  assign pair_out_two_three = pairing_q[usb_regs_pkg::PAIR_OUT23_BIT];
  assign pair_in_six_seven  = pairing_q[usb_regs_pkg::PAIR_IN67_BIT];
  assign pair_in_four_five  = pairing_q[usb_regs_pkg::PAIR_IN45_BIT];
  assign pair_in_two_three  = pairing_q[usb_regs_pkg::PAIR_IN23_BIT];

  // Ten-bit buffer start; low nibble always zero
  assign iso_out_buffer_start = {iso_out_buf_q, {usb_regs_pkg::BUF_ADDR_LSB{1'b0}}};
  assign iso_in_buffer_start  = {iso_in_buf_q, {usb_regs_pkg::BUF_ADDR_LSB{1'b0}}};

  // Filter sees live register values; mask changes act at once
  token_filter u_token_filter (
    .mclk              (mclk),
    .nrst              (nrst),
    .token_valid       (token_valid),
    .token_addr        (token_addr),
    .token_ep          (token_ep),
    .token_is_in       (token_is_in),
    .iso_in_empty      (iso_in_empty),
    .dev_addr          (dev_addr_q),
    .in_mask           (in_mask_q),
    .out_mask          (out_mask_q),
    .iso_in_en         (iso_in_en_q),
    .iso_out_en        (iso_out_en_q),
    .zlr_en            (pairing_q[usb_regs_pkg::ZLR_BIT]),
    .token_respond     (token_respond),
    .token_ignore      (token_ignore),
    .zero_length_reply (zero_length_reply)
  );

endmodule // usb_endpoint_register_set

// [logic/usb_regs_pkg.sv]
// Constants shared by the endpoint register set and its token filter.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit register file.
package usb_regs_pkg;

  // Bus geometry
  localparam int unsigned AXI_ADDR_W = 18;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned AXI_STRB_W = 4;
  localparam int unsigned IDX_W      = 16;
  localparam int unsigned REG_W      = 8;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_FRAME_LOW  = 16'hc7d8;
  localparam logic [15:0] IDX_FRAME_HIGH = 16'hc7d9;
  localparam logic [15:0] IDX_DEV_ADDR   = 16'hc7db;
  localparam logic [15:0] IDX_PAIRING    = 16'hc7dd;
  localparam logic [15:0] IDX_IN_MASK    = 16'hc7de;
  localparam logic [15:0] IDX_OUT_MASK   = 16'hc7df;
  localparam logic [15:0] IDX_ISO_IN_EN  = 16'hc7e0;
  localparam logic [15:0] IDX_ISO_OUT_EN = 16'hc7e1;
  localparam logic [15:0] IDX_ISO_OUT_BUF = 16'hc7f0;
  localparam logic [15:0] IDX_ISO_IN_BUF = 16'hc7f8;
  localparam logic [15:0] IDX_SETUP_BASE = 16'h0ce8;
  localparam int unsigned SETUP_BYTES    = 8;
  localparam int unsigned SETUP_IDX_W    = 3;

  // Field layouts
  localparam int unsigned FRAME_W        = 10;
  localparam int unsigned FRAME_LOW_W    = 8;
  localparam int unsigned DEV_ADDR_W     = 7;
  localparam int unsigned ZLR_BIT        = 7;
  localparam int unsigned PAIR_OUT45_BIT = 4;
  localparam int unsigned PAIR_OUT23_BIT = 3;
  localparam int unsigned PAIR_IN67_BIT  = 2;
  localparam int unsigned PAIR_IN45_BIT  = 1;
  localparam int unsigned PAIR_IN23_BIT  = 0;
  localparam logic [7:0]  PAIR_MASK      = 8'h9f;
  localparam int unsigned EP_MASK_W      = 6;
  localparam int unsigned EP_W           = 4;
  localparam logic [3:0]  EP_BULK_LAST   = 4'h5;
  localparam logic [3:0]  EP_UNMASK_LO   = 4'h6;
  localparam logic [3:0]  EP_UNMASK_HI   = 4'h7;
  localparam logic [3:0]  EP_ISO         = 4'h8;
  localparam int unsigned ISO_EN_BIT     = 0;
  localparam int unsigned BUF_FIELD_LSB  = 2;
  localparam int unsigned BUF_FIELD_W    = 6;
  localparam int unsigned BUF_ADDR_W     = 10;
  localparam int unsigned BUF_ADDR_LSB   = 4;

  // Reset values
  localparam logic [7:0]  RST_REG8       = 8'h00;
  localparam logic [9:0]  RST_FRAME      = 10'h000;
  localparam logic [6:0]  RST_DEV_ADDR   = 7'h00;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : usb_regs_pkg

// [logic/token_filter.sv]
// Token filter: decides, one cycle after a token, whether to answer it.
// Assumes the decoder presents token fields together with a one-cycle strobe.
module token_filter (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            nrst,
  // Decoded token
  input  wire logic                            token_valid,
  input  wire logic [usb_regs_pkg::DEV_ADDR_W-1:0] token_addr,
  input  wire logic [usb_regs_pkg::EP_W-1:0]   token_ep,
  input  wire logic                            token_is_in,
  input  wire logic                            iso_in_empty,
  // Settings from the register file
  input  wire logic [usb_regs_pkg::DEV_ADDR_W-1:0] dev_addr,
  input  wire logic [usb_regs_pkg::EP_MASK_W-1:0] in_mask,
  input  wire logic [usb_regs_pkg::EP_MASK_W-1:0] out_mask,
  input  wire logic                            iso_in_en,
  input  wire logic                            iso_out_en,
  input  wire logic                            zlr_en,
  // Decision, one-cycle pulses
  output logic                                 token_respond,
  output logic                                 token_ignore,
  output logic                                 zero_length_reply
);

  logic addr_match;
  logic ep_enabled;
  logic iso_empty_in;

  // Endpoint enables; 6 and 7 have no mask bit
  always_comb begin
    ep_enabled = 1'b0;
    if (token_ep <= usb_regs_pkg::EP_BULK_LAST) begin
      ep_enabled = token_is_in ? in_mask[token_ep[2:0]] : out_mask[token_ep[2:0]];
    end else if (token_ep == usb_regs_pkg::EP_UNMASK_LO || token_ep == usb_regs_pkg::EP_UNMASK_HI) begin
      ep_enabled = 1'b1;
    end else if (token_ep == usb_regs_pkg::EP_ISO) begin
      ep_enabled = token_is_in ? iso_in_en : iso_out_en;
    end
  end

  assign addr_match   = (token_addr == dev_addr);
  assign iso_empty_in = token_is_in && (token_ep == usb_regs_pkg::EP_ISO) && iso_in_empty;

  // Registered so answers never glitch
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      token_respond     <= 1'b0;
      token_ignore      <= 1'b0;
      zero_length_reply <= 1'b0;
    end else begin
      token_respond     <= token_valid && addr_match && ep_enabled && !iso_empty_in;
      zero_length_reply <= token_valid && addr_match && ep_enabled && iso_empty_in && zlr_en;
      token_ignore      <= token_valid && !(addr_match && ep_enabled && (!iso_empty_in || zlr_en));
    end
  end

endmodule // token_filter

// [testbench/usb_regs_chk.sv]
// Checker: token decisions, buffer fields, bus answers.
// Sees only top-level ports; bound into every register set.
module usb_regs_chk (
  // Clock, reset and decoder events
  input wire logic        mclk, nrst, token_valid, token_is_in, iso_in_empty, addr_set_valid,
  input wire logic [6:0]  token_addr, addr_set_value,
  input wire logic [3:0]  token_ep,
  // Decisions, buffer starts and bus answers
  input wire logic        token_respond, token_ignore, zero_length_reply, rvalid, bvalid, bready,
  input wire logic [9:0]  iso_in_buffer_start, iso_out_buffer_start,
  input wire logic [31:0] rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [6:0] own_q;
  wire logic [2:0] dec = {token_respond, token_ignore, zero_length_reply};
  // Shadow of the assigned address
  always_ff @(posedge mclk) begin
    if (!nrst) own_q <= 7'h00;
    else if (addr_set_valid) own_q <= addr_set_value;
  end
  property p_one; token_valid |=> $onehot(dec); endproperty
  a_one: assert property (p_one) else $error("token answer not exactly one");
  property p_quiet; !token_valid |=> dec == 3'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without token");
  property p_foreign; token_valid && token_addr != own_q |=> token_ignore; endproperty
  a_foreign: assert property (p_foreign) else $error("foreign token answered");
  property p_zlr; zero_length_reply |-> $past(token_ep) == 4'h8 && $past(token_is_in) && $past(iso_in_empty); endproperty
  a_zlr: assert property (p_zlr) else $error("zero-length reply out of place");
  property p_full; token_valid && token_is_in && !iso_in_empty |=> !zero_length_reply; endproperty
  a_full: assert property (p_full) else $error("zero-length reply with data");
  property p_inbuf; iso_in_buffer_start[3:0] == 4'h0; endproperty
  a_inbuf: assert property (p_inbuf) else $error("in buffer start low bits set");
  property p_outbuf; iso_out_buffer_start[3:0] == 4'h0; endproperty
  a_outbuf: assert property (p_outbuf) else $error("out buffer start low bits set");
  property p_rtop; rvalid |-> rdata[31:8] == 24'h0; endproperty
  a_rtop: assert property (p_rtop) else $error("read data upper bits set");
  property p_bdrop; bvalid && bready |=> !bvalid; endproperty
  a_bdrop: assert property (p_bdrop) else $error("write answer held after taken");
endmodule // usb_regs_chk

bind usb_endpoint_register_set usb_regs_chk u_chk (.mclk, .nrst, .token_valid, .token_is_in, .iso_in_empty,
  .addr_set_valid, .token_addr, .addr_set_value, .token_ep, .token_respond, .token_ignore, .zero_length_reply,
  .rvalid, .bvalid, .bready, .iso_in_buffer_start, .iso_out_buffer_start, .rdata);

// [testbench/usb_host_model.sv]
// Host model: decoder events from full-speed host traffic.
// Drives just after rising edges; payloads are inverted once a strobe drops.
module usb_host_model (
  // Clock
  input  wire logic mclk,
  // Strobes and levels
  output logic      sof_valid, addr_set_valid, token_valid, token_is_in, iso_in_empty, setup_start, setup_byte_valid,
  // Payloads
  output logic [9:0] sof_frame,
  output logic [6:0] addr_set_value, token_addr,
  output logic [3:0] token_ep,
  output logic [7:0] setup_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sof_valid, addr_set_valid, token_valid, token_is_in, iso_in_empty, setup_start, setup_byte_valid,
           sof_frame, addr_set_value, token_addr, token_ep, setup_byte} = '0;
  // Each event is a one-cycle strobe with its payload, except setup: a start strobe, then eight byte strobes
  task automatic sof(input logic [9:0] f);
    @(posedge mclk); sof_valid <= 1'b1; sof_frame <= f;
    @(posedge mclk); sof_valid <= 1'b0; sof_frame <= ~f;
  endtask
  task automatic set_addr(input logic [6:0] a);
    @(posedge mclk); addr_set_valid <= 1'b1; addr_set_value <= a;
    @(posedge mclk); addr_set_valid <= 1'b0; addr_set_value <= ~a;
  endtask
  // Buffer-empty level stays as last set
  task automatic token(input logic [6:0] a, input logic [3:0] ep, input logic in, input logic emp);
    @(posedge mclk); token_valid <= 1'b1; token_addr <= a; token_ep <= ep; token_is_in <= in; iso_in_empty <= emp;
    @(posedge mclk); token_valid <= 1'b0; token_addr <= ~a; token_ep <= ~ep;
  endtask
  task automatic setup(input logic [63:0] b);
    @(posedge mclk); setup_start <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk); setup_start <= 1'b0; setup_byte_valid <= 1'b1; setup_byte <= b[8*k +: 8];
    end
    @(posedge mclk); setup_byte_valid <= 1'b0; setup_byte <= ~b[63:56];
  endtask
endmodule // usb_host_model

// [testbench/usb_endpoint_register_set_bench.sv]
// Bench: AXI4-Lite register accesses and host events, checked against expected values.
// Assumes the host model beside it.
module usb_endpoint_register_set_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, token_ep;
  logic [1:0]  bresp, rresp;
  logic        sof_valid, addr_set_valid, token_valid, token_is_in, iso_in_empty, setup_start, setup_byte_valid;
  logic [9:0]  sof_frame, ibs, obs;
  logic [6:0]  addr_set_value, token_addr;
  logic [7:0]  setup_byte;
  logic        tr, ti, tz;
  logic [4:0]  pr;
  int          failures = 0;
  int          n_tests = 0;
  localparam logic [15:0] RW_IDX [7] = '{16'hc7dd, 16'hc7de, 16'hc7df, 16'hc7e0, 16'hc7e1, 16'hc7f0, 16'hc7f8};
  localparam logic [7:0]  RW_MSK [7] = '{8'h9f, 8'h3f, 8'h3f, 8'h01, 8'h01, 8'hfc, 8'hfc};
  // Tokens: {addr, ep, in, empty, respond/ignore/zero-length}
  localparam logic [15:0] TK [10] = '{16'hfe14, 16'hfe32, 16'hfe24, 16'hfe02, 16'h0a12, 16'hff19, 16'hff14,
                                      16'hff02, 16'hff1a, 16'hff12};
  usb_endpoint_register_set u_usb_endpoint_register_set (.mclk, .nrst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .sof_valid, .sof_frame, .addr_set_valid, .addr_set_value, .token_valid, .token_addr, .token_ep,
    .token_is_in, .iso_in_empty, .setup_start, .setup_byte_valid, .setup_byte, .token_respond(tr),
    .token_ignore(ti), .zero_length_reply(tz), .pair_out_four_five(pr[4]), .pair_out_two_three(pr[3]),
    .pair_in_six_seven(pr[2]), .pair_in_four_five(pr[1]), .pair_in_two_three(pr[0]),
    .iso_out_buffer_start(obs), .iso_in_buffer_start(ibs));
  usb_host_model u_usb_host_model (.mclk, .sof_valid, .addr_set_valid, .token_valid, .token_is_in, .iso_in_empty,
    .setup_start, .setup_byte_valid, .sof_frame, .addr_set_value, .token_addr, .token_ep, .setup_byte);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A missing bus answer ends the run
  task automatic tmo(input int n);
    if (n >= 64) begin
      failures++;
      $display("BAD bus answer expected within 64 cycles seen none");
      close_out();
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n = 0;
    @(posedge mclk); awaddr <= {i, 2'b00}; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin @(posedge mclk); n++; if (awready) awvalid <= 1'b0; if (wready) wvalid <= 1'b0; end
    while (!bvalid && n < 64);
    tmo(n); bready <= 1'b0; chk("write response", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input string nm, input logic [15:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
    int n = 0;
    @(posedge mclk); araddr <= {i, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(posedge mclk); n++; if (arready) arvalid <= 1'b0; end while (!rvalid && n < 64);
    tmo(n); rready <= 1'b0; chk(nm, rdata, {24'h0, e}); chk("read response", {30'h0, rresp}, {30'h0, er});
  endtask
  initial begin
    nrst = 1'b0; {awvalid, wvalid, bready, arvalid, rready} = '0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    // Writable registers: zero at reset, fields keep all-ones
    for (int k = 0; k < 7; k++) begin
      rd("reset value", RW_IDX[k], 8'h00);
      wr(RW_IDX[k], 8'hff);
      rd("field mask", RW_IDX[k], RW_MSK[k]);
    end
    chk("pairing", {27'h0, pr}, 32'h1f);
    chk("buffer starts", {12'h0, ibs, obs}, {12'h0, 10'h3f0, 10'h3f0});
    wr(16'hc7d8, 8'hff); rd("frame low write", 16'hc7d8, 8'h00);
    wr(16'h0001, 8'h55, 2'h2); rd("unmapped", 16'h0001, 8'h00, 2'h2);
    $display("registers done");
    u_usb_host_model.sof(10'h3ff);
    rd("frame low", 16'hc7d8, 8'hff); rd("frame high", 16'hc7d9, 8'h03);
    u_usb_host_model.sof(10'h000);
    rd("frame low", 16'hc7d8, 8'h00); rd("frame high", 16'hc7d9, 8'h00);
    u_usb_host_model.set_addr(7'h7f);
    rd("address", 16'hc7db, 8'h7f);
    $display("frame and address done");
    wr(16'hc7de, 8'h01); wr(16'hc7df, 8'h02); wr(16'hc7e1, 8'h00);
    for (int k = 0; k < 10; k++) begin
      if (k == 8) wr(16'hc7dd, 8'h00);
      if (k == 9) wr(16'hc7e0, 8'h00);
      u_usb_host_model.token(TK[k][15:9], TK[k][8:5], TK[k][4], TK[k][3]);
      #1 chk("token answer", {29'h0, tr, ti, tz}, {29'h0, TK[k][2:0]});
    end
    $display("tokens done");
    u_usb_host_model.setup(64'h8877665544332211);
    for (int k = 0; k < 8; k++) rd("setup byte", 16'h0ce8 + 16'(k), 8'(8'h11 * (k + 1)));
    $display("setup done");
    close_out();
  end
endmodule // usb_endpoint_register_set_bench
